// file: rtl/tsg_consts.vh
// Constants of the transmit symbol generator: offsets, fields, reset values
`ifndef TSG_CONSTS_VH
`define TSG_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define TSG_OFF_LONG_SYM_A 8'h00
`define TSG_OFF_LONG_SYM_B 8'h04
`define TSG_OFF_SHORT_SYM_A 8'h08
`define TSG_OFF_SHORT_SYM_B 8'h0c
`define TSG_OFF_LONG_LEN 8'h10
`define TSG_OFF_SHORT_LEN 8'h14
`define TSG_OFF_FRAME_CTRL 8'h18
`define TSG_OFF_LONG_TIMING 8'h1c
`define TSG_OFF_SHORT_TIMING 8'h20
`define TSG_OFF_CTRL_STAT 8'h24

// ------------------------------------------------------------
// Writable bit masks (reserved bits read as zero)
// ------------------------------------------------------------
`define TSG_MASK_LONG_SYM 32'h0000ffff
`define TSG_MASK_SHORT_SYM 32'h000000ff
`define TSG_MASK_LONG_LEN 32'h000fffff
`define TSG_MASK_SHORT_LEN 32'h00000077
`define TSG_MASK_FRAME_CTRL 32'h0000000f
`define TSG_MASK_TIMING 32'h0003ffff

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define TSG_LL_LEN_A_LSB 0
`define TSG_LL_LEN_B_LSB 4
`define TSG_LL_BURST_LSB 8
`define TSG_LL_BEN_A_BIT 16
`define TSG_LL_BEN_B_BIT 17
`define TSG_LL_BVAL_A_BIT 18
`define TSG_LL_BVAL_B_BIT 19
`define TSG_SL_LEN_A_LSB 0
`define TSG_SL_LEN_B_LSB 4
`define TSG_FC_PRE_LSB 0
`define TSG_FC_POST_LSB 2
`define TSG_TM_DIV_LSB 0
`define TSG_TM_CFG_LSB 8
`define TSG_CS_START_BIT 0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TSG_RST_REG 32'h00000000

// ------------------------------------------------------------
// AXI responses
// ------------------------------------------------------------
`define TSG_RESP_OKAY 2'b00
`define TSG_RESP_SLVERR 2'b10

`endif

// file: rtl/tsg_pair_buf.v
// Two-entry valid/ready buffer between the symbol engine and the modulator
`timescale 1ns/1ns
module tsg_pair_buf #(
   parameter W = 13
) (
   aclk,
   aresetn,
   in_valid,
   in_ready,
   in_data,
   out_valid,
   out_ready,
   out_data
);
   input wire aclk;
   input wire aresetn;
   input wire in_valid;
   output wire in_ready;
   input wire [W-1:0] in_data;
   output wire out_valid;
   input wire out_ready;
   output wire [W-1:0] out_data;

   reg [W-1:0] mem_q [0:1];
   reg wr_ptr_q;
   reg rd_ptr_q;
   reg [1:0] cnt_q;
   wire push;
   wire pop;

   assign in_ready = (cnt_q != 2'd2);
   assign out_valid = (cnt_q != 2'd0);
   assign out_data = mem_q[rd_ptr_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q <= 2'd0;
         mem_q[0] <= {W{1'b0}};
         mem_q[1] <= {W{1'b0}};
      end else begin
         if (push) begin
            mem_q[wr_ptr_q] <= in_data;
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 2'd1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 2'd1;
         end
      end
   end
endmodule

// file: rtl/tsg_symbol_gen.v
// Transmit symbol generator with AXI4-Lite register slave
// Function
// - Two long symbols take 16-bit patterns plus optional constant burst up to 256 bits.
// - Two short symbols take patterns up to 8 bits and never burst.
// - Register LSB holds the last pattern bit sent; earlier bits sit higher.
// - Length bounds pattern; higher bits ignored; sending runs from length bit down to 0.
// - Frame control picks pre symbol from first three, post from last three.
// - Long pair shares one timing config, short pair another.
`timescale 1ns/1ns
`include "tsg_consts.vh"
module tsg_symbol_gen (
   aclk,
   aresetn,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_awaddr,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_bresp,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_araddr,
   s_axi_rvalid,
   s_axi_rready,
   s_axi_rdata,
   s_axi_rresp,
   data_valid,
   data_ready,
   data_bit,
   data_last,
   tx_valid,
   tx_ready,
   tx_bit,
   tx_is_symbol,
   tx_pair,
   tx_config
);
   input wire aclk;
   input wire aresetn;
   input wire s_axi_awvalid;
   output reg s_axi_awready;
   input wire [7:0] s_axi_awaddr;
   input wire s_axi_wvalid;
   output reg s_axi_wready;
   input wire [31:0] s_axi_wdata;
   input wire [3:0] s_axi_wstrb;
   output reg s_axi_bvalid;
   input wire s_axi_bready;
   output reg [1:0] s_axi_bresp;
   input wire s_axi_arvalid;
   output wire s_axi_arready;
   input wire [7:0] s_axi_araddr;
   output reg s_axi_rvalid;
   input wire s_axi_rready;
   output reg [31:0] s_axi_rdata;
   output reg [1:0] s_axi_rresp;
   input wire data_valid;
   output wire data_ready;
   input wire data_bit;
   input wire data_last;
   output wire tx_valid;
   input wire tx_ready;
   output wire tx_bit;
   output wire tx_is_symbol;
   output wire tx_pair;
   output wire [9:0] tx_config;

   localparam ST_IDLE = 2'd0;
   localparam ST_PRE = 2'd1;
   localparam ST_DATA = 2'd2;
   localparam ST_POST = 2'd3;

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   reg [31:0] long_symbol_a_q;
   reg [31:0] long_symbol_b_q;
   reg [31:0] short_symbol_a_q;
   reg [31:0] short_symbol_b_q;
   reg [31:0] long_symbols_length_q;
   reg [31:0] short_symbols_length_q;
   reg [31:0] tx_frame_control_q;
   reg [31:0] long_timing_q;
   reg [31:0] short_timing_q;
   reg start_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg have_aw_q;
   reg have_w_q;
   reg [1:0] state_q;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] strb;
      input [31:0] mask;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = wd[i*8 +: 8];
            end
         end
         merge = merge & mask;
      end
   endfunction

   wire do_write;
   assign do_write = have_aw_q && have_w_q && !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TSG_RESP_OKAY;
         have_aw_q <= 1'b0;
         have_w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         long_symbol_a_q <= `TSG_RST_REG;
         long_symbol_b_q <= `TSG_RST_REG;
         short_symbol_a_q <= `TSG_RST_REG;
         short_symbol_b_q <= `TSG_RST_REG;
         long_symbols_length_q <= `TSG_RST_REG;
         short_symbols_length_q <= `TSG_RST_REG;
         tx_frame_control_q <= `TSG_RST_REG;
         long_timing_q <= `TSG_RST_REG;
         short_timing_q <= `TSG_RST_REG;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            have_aw_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            have_w_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `TSG_RESP_OKAY;
            if (awaddr_q == `TSG_OFF_LONG_SYM_A) begin
               long_symbol_a_q <= merge(long_symbol_a_q, wdata_q, wstrb_q, `TSG_MASK_LONG_SYM);
            end else if (awaddr_q == `TSG_OFF_LONG_SYM_B) begin
               long_symbol_b_q <= merge(long_symbol_b_q, wdata_q, wstrb_q, `TSG_MASK_LONG_SYM);
            end else if (awaddr_q == `TSG_OFF_SHORT_SYM_A) begin
               short_symbol_a_q <= merge(short_symbol_a_q, wdata_q, wstrb_q, `TSG_MASK_SHORT_SYM);
            end else if (awaddr_q == `TSG_OFF_SHORT_SYM_B) begin
               short_symbol_b_q <= merge(short_symbol_b_q, wdata_q, wstrb_q, `TSG_MASK_SHORT_SYM);
            end else if (awaddr_q == `TSG_OFF_LONG_LEN) begin
               long_symbols_length_q <= merge(long_symbols_length_q, wdata_q, wstrb_q,
                  `TSG_MASK_LONG_LEN);
            end else if (awaddr_q == `TSG_OFF_SHORT_LEN) begin
               short_symbols_length_q <= merge(short_symbols_length_q, wdata_q, wstrb_q,
                  `TSG_MASK_SHORT_LEN);
            end else if (awaddr_q == `TSG_OFF_FRAME_CTRL) begin
               tx_frame_control_q <= merge(tx_frame_control_q, wdata_q, wstrb_q,
                  `TSG_MASK_FRAME_CTRL);
            end else if (awaddr_q == `TSG_OFF_LONG_TIMING) begin
               long_timing_q <= merge(long_timing_q, wdata_q, wstrb_q, `TSG_MASK_TIMING);
            end else if (awaddr_q == `TSG_OFF_SHORT_TIMING) begin
               short_timing_q <= merge(short_timing_q, wdata_q, wstrb_q, `TSG_MASK_TIMING);
            end else if (awaddr_q == `TSG_OFF_CTRL_STAT) begin
               // A start while a frame is running is dropped
               start_q <= wstrb_q[0] && wdata_q[`TSG_CS_START_BIT] && (state_q == ST_IDLE);
            end else begin
               s_axi_bresp <= `TSG_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TSG_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `TSG_RESP_OKAY;
         if (s_axi_araddr == `TSG_OFF_LONG_SYM_A) begin
            s_axi_rdata <= long_symbol_a_q;
         end else if (s_axi_araddr == `TSG_OFF_LONG_SYM_B) begin
            s_axi_rdata <= long_symbol_b_q;
         end else if (s_axi_araddr == `TSG_OFF_SHORT_SYM_A) begin
            s_axi_rdata <= short_symbol_a_q;
         end else if (s_axi_araddr == `TSG_OFF_SHORT_SYM_B) begin
            s_axi_rdata <= short_symbol_b_q;
         end else if (s_axi_araddr == `TSG_OFF_LONG_LEN) begin
            s_axi_rdata <= long_symbols_length_q;
         end else if (s_axi_araddr == `TSG_OFF_SHORT_LEN) begin
            s_axi_rdata <= short_symbols_length_q;
         end else if (s_axi_araddr == `TSG_OFF_FRAME_CTRL) begin
            s_axi_rdata <= tx_frame_control_q;
         end else if (s_axi_araddr == `TSG_OFF_LONG_TIMING) begin
            s_axi_rdata <= long_timing_q;
         end else if (s_axi_araddr == `TSG_OFF_SHORT_TIMING) begin
            s_axi_rdata <= short_timing_q;
         end else if (s_axi_araddr == `TSG_OFF_CTRL_STAT) begin
            s_axi_rdata <= {29'h00000000, state_q, (state_q != ST_IDLE)};
         end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TSG_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Symbol selection
   // ------------------------------------------------------------
   // Selector codes 0 = none; pre codes map to long a, long b, short a and post codes to
   // long b, short a, short b, so no illegal symbol can be chosen.
   wire [1:0] pre_sel = tx_frame_control_q[`TSG_FC_PRE_LSB +: 2];
   wire [1:0] post_sel = tx_frame_control_q[`TSG_FC_POST_LSB +: 2];
   reg [15:0] ld_pat;
   reg [3:0] ld_len;
   reg ld_ben;
   reg ld_bval;
   reg ld_pair;
   reg [1:0] ld_sym;

   always @* begin
      ld_sym = (state_q == ST_IDLE) ? pre_sel - 2'd1 : post_sel;
      ld_pat = long_symbol_a_q[15:0];
      ld_len = long_symbols_length_q[`TSG_LL_LEN_A_LSB +: 4];
      ld_ben = long_symbols_length_q[`TSG_LL_BEN_A_BIT];
      ld_bval = long_symbols_length_q[`TSG_LL_BVAL_A_BIT];
      ld_pair = 1'b0;
      case (ld_sym)
         2'd1: begin
            ld_pat = long_symbol_b_q[15:0];
            ld_len = long_symbols_length_q[`TSG_LL_LEN_B_LSB +: 4];
            ld_ben = long_symbols_length_q[`TSG_LL_BEN_B_BIT];
            ld_bval = long_symbols_length_q[`TSG_LL_BVAL_B_BIT];
         end
         2'd2: begin
            // Short symbols never burst
            ld_pat = {8'h00, short_symbol_a_q[7:0]};
            ld_len = {1'b0, short_symbols_length_q[`TSG_SL_LEN_A_LSB +: 3]};
            ld_ben = 1'b0;
            ld_pair = 1'b1;
         end
         2'd3: begin
            ld_pat = {8'h00, short_symbol_b_q[7:0]};
            ld_len = {1'b0, short_symbols_length_q[`TSG_SL_LEN_B_LSB +: 3]};
            ld_ben = 1'b0;
            ld_pair = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // ------------------------------------------------------------
   // Bit engine
   // ------------------------------------------------------------
   reg [15:0] pat_q;
   reg [3:0] idx_q;
   reg in_burst_q;
   reg [8:0] burst_q;
   reg ben_q;
   reg bval_q;
   reg pair_q;
   reg [7:0] tmr_q;
   wire buf_ready;
   wire sym_active = (state_q == ST_PRE) || (state_q == ST_POST);
   wire tick = (tmr_q == 8'h00);
   // Pair 0 timing also paces the data phase
   wire [31:0] cfg = (sym_active && pair_q) ? short_timing_q : long_timing_q;
   wire sym_bit = in_burst_q ? bval_q : pat_q[idx_q];
   wire sym_push = sym_active && tick && buf_ready;
   wire dat_push = (state_q == ST_DATA) && tick && buf_ready && data_valid;
   wire sym_end = in_burst_q ? (burst_q == 9'd1) : ((idx_q == 4'd0) && !ben_q);
   wire [12:0] buf_in = {cfg[`TSG_TM_CFG_LSB +: 10], sym_active && pair_q, sym_active,
      sym_active ? sym_bit : data_bit};

   assign data_ready = (state_q == ST_DATA) && tick && buf_ready;

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_IDLE;
         pat_q <= 16'h0000;
         idx_q <= 4'h0;
         in_burst_q <= 1'b0;
         burst_q <= 9'h000;
         ben_q <= 1'b0;
         bval_q <= 1'b0;
         pair_q <= 1'b0;
         tmr_q <= 8'h00;
      end else begin
         if (!tick) begin
            tmr_q <= tmr_q - 8'h01;
         end else if (sym_push || dat_push) begin
            // Stall by the modulator freezes the timer at zero
            tmr_q <= cfg[`TSG_TM_DIV_LSB +: 8];
         end
         case (state_q)
            ST_IDLE: begin
               if (start_q) begin
                  tmr_q <= 8'h00;
                  pat_q <= ld_pat;
                  idx_q <= ld_len;
                  ben_q <= ld_ben;
                  bval_q <= ld_bval;
                  pair_q <= ld_pair;
                  in_burst_q <= 1'b0;
                  state_q <= (pre_sel == 2'd0) ? ST_DATA : ST_PRE;
               end
            end
            ST_PRE, ST_POST: begin
               if (sym_push) begin
                  if (sym_end) begin
                     in_burst_q <= 1'b0;
                     if (state_q == ST_POST) begin
                        state_q <= ST_IDLE;
                     end else begin
                        state_q <= ST_DATA;
                     end
                  end else if (in_burst_q) begin
                     burst_q <= burst_q - 9'd1;
                  end else if (idx_q == 4'd0) begin
                     // Burst length field n gives n+1 bits
                     in_burst_q <= 1'b1;
                     burst_q <= {1'b0, long_symbols_length_q[`TSG_LL_BURST_LSB +: 8]} + 9'd1;
                  end else begin
                     idx_q <= idx_q - 4'd1;
                  end
               end
            end
            default: begin
               if (dat_push && data_last) begin
                  pat_q <= ld_pat;
                  idx_q <= ld_len;
                  ben_q <= ld_ben;
                  bval_q <= ld_bval;
                  pair_q <= ld_pair;
                  state_q <= (post_sel == 2'd0) ? ST_IDLE : ST_POST;
               end
            end
         endcase
      end
   end

   tsg_pair_buf #(
      .W(13)
   ) u_buf (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(sym_push || dat_push),
      .in_ready(buf_ready),
      .in_data(buf_in),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data({tx_config, tx_pair, tx_is_symbol, tx_bit})
   );
endmodule

// file: tb/tsg_checker.sv
// Port-level assertions for the transmit symbol generator
`timescale 1ns/1ns
module tsg_checker (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire data_valid,
   input wire data_ready,
   input wire tx_valid,
   input wire tx_ready,
   input wire tx_bit,
   input wire tx_is_symbol,
   input wire tx_pair,
   input wire [9:0] tx_config
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] short_run_q;
   // ------------------------------------------------------------
   // Run of short-pair bits; any write restarts it since a start needs one
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn || s_axi_awvalid) begin
         short_run_q <= 4'h0;
      end else if (tx_valid && tx_ready) begin
         short_run_q <= (tx_is_symbol && tx_pair) ? short_run_q + 4'h1 : 4'h0;
      end
   end
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid &&
      $stable({tx_bit, tx_is_symbol, tx_pair, tx_config})) else $error("tx bit changed in stall");
   AST_DATA_LONG: assert property (tx_valid && !tx_is_symbol |-> !tx_pair)
      else $error("data bit not on long pair");
   AST_SHORT_MAX: assert property (short_run_q <= 4'h8)
      else $error("short symbol longer than eight bits");
   AST_DATA_PUSH: assert property (data_valid && data_ready |=> tx_valid)
      else $error("taken data bit not offered");
   // Both halves land in holding flops first, so the response rises one edge later
   AST_B_AFTER_W: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write response missing");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
      $stable(s_axi_bresp)) else $error("write response dropped");
   AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
      $stable(s_axi_rdata)) else $error("read data dropped");
   AST_ONE_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("second write accepted");
endmodule
bind tsg_symbol_gen tsg_checker i_chk (.*);

// file: tb/tsg_mod_model.sv
// Behavioural modulator taking serial bits from the generator
`timescale 1ns/1ns
module tsg_mod_model (
   input wire aclk,
   input wire aresetn,
   input wire stall,
   input wire tx_valid,
   output logic tx_ready,
   input wire tx_bit,
   input wire tx_is_symbol,
   input wire tx_pair,
   input wire [9:0] tx_config
);
   logic [12:0] got[$];
   int got_t[$];
   int cyc = 0;
   // Slow mode takes one bit in three clocks so the buffer fills and refuses
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      tx_ready <= aresetn && (!stall || (cyc % 3 == 0));
      if (aresetn && tx_valid && tx_ready) begin
         got.push_back({tx_is_symbol, tx_pair, tx_config, tx_bit});
         got_t.push_back(cyc);
      end
   end
endmodule

// file: tb/tb_tsg_symbol_gen.sv
// Self-checking bench: register access and frame assembly
`timescale 1ns/1ns
`include "tsg_consts.vh"
module tb_tsg_symbol_gen;
   logic aclk, aresetn, stall, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, data_valid, data_ready, data_bit, data_last;
   logic tx_valid, tx_ready, tx_bit, tx_is_symbol, tx_pair;
   logic [9:0] tx_config;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rv[0:8];
   logic [31:0] mk[0:8] = '{`TSG_MASK_LONG_SYM, `TSG_MASK_LONG_SYM, `TSG_MASK_SHORT_SYM,
      `TSG_MASK_SHORT_SYM, `TSG_MASK_LONG_LEN, `TSG_MASK_SHORT_LEN, `TSG_MASK_FRAME_CTRL,
      `TSG_MASK_TIMING, `TSG_MASK_TIMING};
   logic [31:0] cfg[0:8] = '{32'hdeadc3a5, 32'h0000fff6, 32'h000000ea, 32'h00000081,
      32'h0007ff3f, 32'h00000005, 32'h0, 32'h0002a500, 32'h00015a02};
   logic [7:0] dpat = 8'h6d;
   logic [12:0] exp_q[$];
   int n_fail = 0;
   int samples_checked = 0;

   tsg_symbol_gen i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .data_valid(data_valid), .data_ready(data_ready), .data_bit(data_bit),
      .data_last(data_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_bit(tx_bit),
      .tx_is_symbol(tx_is_symbol), .tx_pair(tx_pair), .tx_config(tx_config));
   tsg_mod_model i_mod (.aclk(aclk), .aresetn(aresetn), .stall(stall), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_bit(tx_bit), .tx_is_symbol(tx_is_symbol), .tx_pair(tx_pair),
      .tx_config(tx_config));

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task print_verdict;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task do_reset;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rv[i]) rv[i] = 32'h0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
      logic aw_done, w_done;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      bready <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(bresp, e);
      // Shadow copy keeps only the bytes enabled and the implemented bits
      if (a < `TSG_OFF_CTRL_STAT) begin
         for (int b = 0; b < 4; b++) if (s[b]) rv[a >> 2][8 * b +: 8] = d[8 * b +: 8];
         rv[a >> 2] &= mk[a >> 2];
      end
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      rs = rresp;
   endtask

   task rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      rd(a, v, r);
      chk(v, e);
      chk(r, er);
   endtask

   // Slot code: 0 none, 1 long A, 2 long B, 3 short A, 4 short B
   task add_sym(input int s);
      int n;
      logic pr;
      logic [9:0] cf;
      if (s == 0) return;
      case (s)
         1: n = rv[4][3:0];
         2: n = rv[4][7:4];
         3: n = rv[5][2:0];
         default: n = rv[5][6:4];
      endcase
      pr = (s > 2);
      cf = pr ? rv[8][17:8] : rv[7][17:8];
      for (int i = n; i >= 0; i--) exp_q.push_back({1'b1, pr, cf, rv[s - 1][i]});
      if (s < 3 && rv[4][15 + s]) begin
         repeat (rv[4][15:8] + 1) exp_q.push_back({1'b1, pr, cf, rv[4][17 + s]});
      end
   endtask

   task run_frame(input logic [3:0] fc, input int nd, input logic sl);
      stall <= sl;
      exp_q.delete();
      i_mod.got.delete();
      i_mod.got_t.delete();
      wr(`TSG_OFF_FRAME_CTRL, {28'h0, fc}, 4'hf, `TSG_RESP_OKAY);
      add_sym(fc[1:0]);
      for (int i = 0; i < nd; i++) exp_q.push_back({2'b00, rv[7][17:8], dpat[i]});
      add_sym(fc[3:2] == 2'd0 ? 0 : fc[3:2] + 1);
      wr(`TSG_OFF_CTRL_STAT, 32'h1, 4'hf, `TSG_RESP_OKAY);
      rd(`TSG_OFF_CTRL_STAT, v, r);
      chk(v[0], 1'b1);
      data_valid <= 1'b1;
      for (int i = 0; i < nd; i++) begin
         data_bit <= dpat[i];
         data_last <= (i == nd - 1);
         do @(posedge aclk); while (data_ready !== 1'b1);
      end
      data_valid <= 1'b0;
      for (int t = 0; t < 20000 && i_mod.got.size() < exp_q.size(); t++) @(posedge aclk);
      chk(i_mod.got.size(), exp_q.size());
      foreach (exp_q[i]) if (i < i_mod.got.size()) chk(i_mod.got[i], exp_q[i]);
      if (!sl && fc[1:0] != 2'd0) begin
         chk(i_mod.got_t[1] - i_mod.got_t[0], rv[fc[1:0] == 2'd3 ? 8 : 7][7:0] + 1);
      end
      do rd(`TSG_OFF_CTRL_STAT, v, r); while (v[0] !== 1'b0);
      chk(v, 32'h0);
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, data_valid, data_bit, data_last} = 8'h0;
      {awaddr, araddr, wdata, wstrb, stall, aresetn} = '0;
      do_reset;
      for (int i = 0; i < 10; i++) rdchk(8'(4 * i), 32'h0, `TSG_RESP_OKAY);
      rdchk(8'h28, 32'h0, `TSG_RESP_SLVERR);
      wr(8'h2c, 32'hffffffff, 4'hf, `TSG_RESP_SLVERR);
      for (int i = 0; i < 9; i++) begin
         wr(8'(4 * i), 32'hffffffff, 4'hf, `TSG_RESP_OKAY);
         rdchk(8'(4 * i), mk[i], `TSG_RESP_OKAY);
      end
      wr(`TSG_OFF_LONG_SYM_A, 32'h12345678, 4'h2, `TSG_RESP_OKAY);
      rdchk(`TSG_OFF_LONG_SYM_A, 32'h000056ff, `TSG_RESP_OKAY);
      do_reset;
      rdchk(`TSG_OFF_LONG_LEN, 32'h0, `TSG_RESP_OKAY);
      foreach (cfg[i]) wr(8'(4 * i), cfg[i], 4'hf, `TSG_RESP_OKAY);
      run_frame(4'h5, 3, 1'b0);
      wr(`TSG_OFF_LONG_LEN, 32'h0007003f, 4'hf, `TSG_RESP_OKAY);
      wr(`TSG_OFF_SHORT_LEN, 32'h7, 4'hf, `TSG_RESP_OKAY);
      run_frame(4'ha, 5, 1'b1);
      wr(`TSG_OFF_SHORT_LEN, 32'h5, 4'hf, `TSG_RESP_OKAY);
      run_frame(4'hf, 2, 1'b0);
      run_frame(4'h0, 1, 1'b1);
      print_verdict;
   end

   initial begin
      repeat (40000) @(posedge aclk);
      n_fail++;
      print_verdict;
   end
endmodule
